// ===== design/cdt_pkg.sv
// Package for the cascadable down timers: offsets, fields, resets, bus carrier
package cdt_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int CDT_ADDR_W = 13;
    localparam logic [12:0] CDT_MODULE_STRIDE = 13'h1000; // Second module base
    localparam logic [12:0] CDT_TIMER_STRIDE = 13'h0020; // Second timer in a module
    localparam logic [3:0] CDT_OFS_RELOAD = 4'h0; // reload_value
    localparam logic [3:0] CDT_OFS_COUNT = 4'h4; // count_readback
    localparam logic [3:0] CDT_OFS_SETUP = 4'h8; // timer_setup
    localparam logic [3:0] CDT_OFS_ACK = 4'hc; // irq_acknowledge
    localparam int CDT_MODULE_BIT = 12;
    localparam int CDT_TIMER_BIT = 5;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int CDT_SETUP_EN_BIT = 7;
    localparam int CDT_SETUP_MODE_BIT = 6;
    localparam int CDT_SETUP_CASC_BIT = 4;
    localparam int CDT_SETUP_PRES_LSB = 2;
    localparam logic [15:0] CDT_COUNT_RESET = 16'hffff;
    localparam logic [15:0] CDT_COUNT_ZERO = 16'h0000;
    localparam logic [15:0] CDT_COUNT_ONE = 16'h0001;
    localparam logic [15:0] CDT_RELOAD_RESET = 16'h0000;
    localparam int CDT_NUM_TIMERS = 4;
    localparam int CDT_TIMERS_PER_MODULE = 2;

    // ------------------------------------------------------------
    // Peripheral bus request carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [12:0] paddr;
        logic [31:0] pwdata;
    } cdt_apb_req_t;
endpackage

// ===== design/cdt_timers.sv
// Four 16-bit down timers in two modules, timers 1 to 3 cascadable, with peripheral bus registers
`timescale 1ns/1ps
`default_nettype none

module cdt_timers
    import cdt_pkg::*;
#(
    parameter int NUM_TIMERS = CDT_NUM_TIMERS
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire cdt_apb_req_t apb_req,
    output logic [31:0] prdata,
    input wire logic tick_module_a,
    input wire logic tick_module_b,
    output logic [3:0] timer_irq,
    output logic timer_out
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (NUM_TIMERS != CDT_NUM_TIMERS) begin : g_bad_count
        $error("cdt_timers: the timer count is fixed at four");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0][15:0] count;
        logic [3:0][15:0] reload;
        logic [3:0] en;
        logic [3:0] mode;
        logic [3:0] casc;
        logic [3:0][1:0] pres;
        logic [3:0] irq;
        logic tout;
        logic [31:0] rdata;
    } cdt_state_t;

    cdt_state_t s_q;
    cdt_state_t s_d;

    logic [3:0] base_tick;
    logic [3:0] src_tick;
    logic [3:0] carry;
    logic [3:0] hit;
    logic [3:0] wr_sel;
    logic [3:0] en_rise;
    logic [1:0] acc_idx;
    logic [3:0] acc_ofs;
    logic acc_ok;
    logic wr_acc;
    logic rd_setup;

    // Address decode: module bit, timer-in-module bit, word offset
    assign acc_idx = {apb_req.paddr[CDT_MODULE_BIT], apb_req.paddr[CDT_TIMER_BIT]};
    assign acc_ofs = apb_req.paddr[3:0];
    assign acc_ok = (apb_req.paddr[11:6] == 6'h00) && (apb_req.paddr[4] == 1'b0);
    assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite && acc_ok;
    assign rd_setup = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

    // Module A tick feeds timers 0,1; module B tick feeds timers 2,3
    assign base_tick = {tick_module_b, tick_module_b, tick_module_a, tick_module_a};

    // Per-timer tick source, underflow carry and write select
    for (genvar i = 0; i < 4; i++) begin : g_timer
        if (i == 0) begin : g_first
            assign src_tick[i] = base_tick[i];
        end else begin : g_next
            // Only the immediately lower timer can feed this one
            assign src_tick[i] = s_q.casc[i] ? carry[i-1] : base_tick[i];
        end
        assign hit[i] = s_q.en[i] && src_tick[i];
        assign carry[i] = hit[i] && (s_q.count[i] == CDT_COUNT_ZERO);
        assign wr_sel[i] = wr_acc && (acc_idx == 2'(i));
        assign en_rise[i] = wr_sel[i] && (acc_ofs == CDT_OFS_SETUP) && !s_q.en[i]
            && apb_req.pwdata[CDT_SETUP_EN_BIT];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic next_casc;
        next_casc = 1'b0;
        s_d = s_q;
        for (int i = 0; i < 4; i++) begin
            next_casc = (i < 3) ? s_q.casc[(i + 1) % 4] : 1'b0;
            // Counter: enable load, periodic reload, free-run wrap, decrement
            if (en_rise[i]) begin
                s_d.count[i] = s_q.reload[i];
            end else if (carry[i]) begin
                if (s_q.mode[i]) begin
                    s_d.count[i] = s_q.reload[i];
                end else begin
                    s_d.count[i] = CDT_COUNT_RESET;
                end
            end else if (hit[i]) begin
                s_d.count[i] = s_q.count[i] - CDT_COUNT_ONE;
            end
            // Register writes
            if (wr_sel[i] && acc_ofs == CDT_OFS_RELOAD) begin
                s_d.reload[i] = apb_req.pwdata[15:0];
            end
            if (wr_sel[i] && acc_ofs == CDT_OFS_SETUP) begin
                s_d.en[i] = apb_req.pwdata[CDT_SETUP_EN_BIT];
                s_d.mode[i] = apb_req.pwdata[CDT_SETUP_MODE_BIT];
                s_d.casc[i] = apb_req.pwdata[CDT_SETUP_CASC_BIT];
                s_d.pres[i] = apb_req.pwdata[CDT_SETUP_PRES_LSB +: 2];
            end
            // Interrupt: acknowledge clears, a new underflow wins over it
            if (wr_sel[i] && acc_ofs == CDT_OFS_ACK) begin
                s_d.irq[i] = 1'b0;
            end
            if (carry[i] && !next_casc) begin
                s_d.irq[i] = 1'b1;
            end
        end
        // Timer 3 arriving at zero flips the pin
        if (hit[3] && !en_rise[3] && s_q.count[3] == CDT_COUNT_ONE) begin
            s_d.tout = !s_q.tout;
        end
        // Read data captured in setup phase, valid through access phase
        if (rd_setup) begin
            s_d.rdata = 32'h0000_0000;
            if (acc_ok) begin
                unique case (acc_ofs)
                    CDT_OFS_RELOAD: s_d.rdata = {16'h0000, s_q.reload[acc_idx]};
                    CDT_OFS_COUNT: s_d.rdata = {16'h0000, s_q.count[acc_idx]};
                    CDT_OFS_SETUP: s_d.rdata = {24'h00_0000, s_q.en[acc_idx],
                        s_q.mode[acc_idx], 1'b0, s_q.casc[acc_idx], s_q.pres[acc_idx], 2'b00};
                    default: s_d.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_q <= '0;
            for (int i = 0; i < 4; i++) begin
                s_q.count[i] <= CDT_COUNT_RESET;
                s_q.reload[i] <= CDT_RELOAD_RESET;
            end
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops; bit n feeds controller line 17+n
    assign timer_irq = s_q.irq;
    assign timer_out = s_q.tout;
    assign prdata = s_q.rdata;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_free_wrap;
        (carry[0] && !s_q.mode[0] && !en_rise[0]) |=> (s_q.count[0] == 16'hffff);
    endproperty
    a_free_wrap: assert property (p_free_wrap) else $error("free-run wrap missed");

    property p_periodic_reload;
        (carry[2] && s_q.mode[2] && !en_rise[2]) |=> (s_q.count[2] == $past(s_q.reload[2]));
    endproperty
    a_periodic_reload: assert property (p_periodic_reload) else $error("no reload");

    sequence s_enable_write;
        en_rise[0] && !(wr_sel[0] && acc_ofs == CDT_OFS_RELOAD);
    endsequence
    property p_enable_load;
        s_enable_write |=> (s_q.count[0] == $past(s_q.reload[0])) && s_q.en[0];
    endproperty
    a_enable_load: assert property (p_enable_load) else $error("enable load missed");

    property p_out_toggle;
        (s_q.count[3] == 16'h0000 && $past(s_q.count[3]) == 16'h0001 && !$past(en_rise[3]))
            |-> (timer_out != $past(timer_out));
    endproperty
    a_out_toggle: assert property (p_out_toggle) else $error("output not toggled");

    property p_chain_step;
        (s_q.casc[3] && s_q.en[3] && !carry[2] && !en_rise[3]) |=> $stable(s_q.count[3]);
    endproperty
    a_chain_step: assert property (p_chain_step) else $error("chained timer stepped");

    property p_irq_suppress;
        (s_q.casc[3] && !s_q.irq[2]) |=> !s_q.irq[2];
    endproperty
    a_irq_suppress: assert property (p_irq_suppress) else $error("chained irq raised");

    property p_irq_set;
        (carry[3]) |=> timer_irq[3];
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("wrap without irq");

    property p_ack_clear;
        (wr_sel[0] && acc_ofs == CDT_OFS_ACK && !carry[0]) |=> !timer_irq[0];
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("irq not cleared");

    property p_readback;
        (rd_setup && acc_ok && acc_ofs == CDT_OFS_COUNT)
            |=> (prdata == {16'h0000, $past(s_q.count[acc_idx])}) ##1 $stable(prdata) [*1];
    endproperty
    a_readback: assert property (p_readback) else $error("bad count readback");

    // ------------------------------------------------------------
    // Counting and chaining
    // ------------------------------------------------------------
    property p_free_step;
        (hit[0] && !carry[0] && !en_rise[0])
            |=> (s_q.count[0] == $past(s_q.count[0]) - 16'h0001);
    endproperty
    a_free_step: assert property (p_free_step) else $error("free-run step missed");

    property p_casc0_counts;
        (s_q.casc[0] && s_q.en[0] && !s_q.mode[0] && tick_module_a && !en_rise[0])
            |=> (s_q.count[0] != $past(s_q.count[0]));
    endproperty
    a_casc0_counts: assert property (p_casc0_counts) else $error("timer 0 stalled");

    property p_idle_hold;
        (!s_q.en[1] && !en_rise[1]) |=> $stable(s_q.count[1]);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("disabled timer moved");

    property p_solo_step;
        (!s_q.casc[1] && s_q.en[1] && tick_module_a && !carry[1] && !en_rise[1])
            |=> (s_q.count[1] == $past(s_q.count[1]) - 16'h0001);
    endproperty
    a_solo_step: assert property (p_solo_step) else $error("unchained step missed");

    // Carry of timer 2 is the only clock of a chained timer 3
    sequence s_chain_tick;
        s_q.casc[3] && s_q.en[3] && carry[2] && !en_rise[3] && (s_q.count[3] != 16'h0000);
    endsequence
    property p_chain_follow;
        s_chain_tick |=> (s_q.count[3] == $past(s_q.count[3]) - 16'h0001);
    endproperty
    a_chain_follow: assert property (p_chain_follow) else $error("chain step missed");

    property p_tick_b_idle;
        (!tick_module_b && !s_q.casc[2] && !en_rise[2]) |=> $stable(s_q.count[2]);
    endproperty
    a_tick_b_idle: assert property (p_tick_b_idle) else $error("timer 2 moved");

    property p_tick_a_idle;
        (!tick_module_a && !en_rise[0]) |=> $stable(s_q.count[0]);
    endproperty
    a_tick_a_idle: assert property (p_tick_a_idle) else $error("timer 0 moved");

    // ------------------------------------------------------------
    // Interrupt lines
    // ------------------------------------------------------------
    property p_periodic_irq;
        (carry[1] && s_q.mode[1] && !s_q.casc[2]) |=> timer_irq[1];
    endproperty
    a_periodic_irq: assert property (p_periodic_irq) else $error("periodic irq lost");

    property p_irq_hold;
        (timer_irq[1] && !(wr_sel[1] && acc_ofs == CDT_OFS_ACK)) |=> timer_irq[1];
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");

    property p_irq_cause;
        (!timer_irq[2] && !carry[2]) |=> !timer_irq[2];
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without carry");

    // ------------------------------------------------------------
    // Output pin and register access
    // ------------------------------------------------------------
    property p_out_hold;
        !(hit[3] && s_q.count[3] == 16'h0001) |=> $stable(timer_out);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output moved");

    property p_reload_write;
        (wr_sel[1] && acc_ofs == CDT_OFS_RELOAD)
            |=> (s_q.reload[1] == $past(apb_req.pwdata[15:0]));
    endproperty
    a_reload_write: assert property (p_reload_write) else $error("reload not stored");

    property p_setup_write;
        (wr_sel[3] && acc_ofs == CDT_OFS_SETUP)
            |=> (s_q.en[3] == $past(apb_req.pwdata[CDT_SETUP_EN_BIT]))
                && (s_q.mode[3] == $past(apb_req.pwdata[CDT_SETUP_MODE_BIT]))
                && (s_q.casc[3] == $past(apb_req.pwdata[CDT_SETUP_CASC_BIT]));
    endproperty
    a_setup_write: assert property (p_setup_write) else $error("control not stored");

    property p_count_ro;
        (wr_sel[2] && acc_ofs == CDT_OFS_COUNT && !s_q.en[2])
            |=> $stable(s_q.count[2]);
    endproperty
    a_count_ro: assert property (p_count_ro) else $error("count written");

    property p_block_apart;
        (wr_acc && acc_idx == 2'h3) |=> $stable(s_q.reload[2]);
    endproperty
    a_block_apart: assert property (p_block_apart) else $error("wrong timer written");

    property p_read_reload;
        (rd_setup && acc_ok && acc_ofs == CDT_OFS_RELOAD)
            |=> (prdata == {16'h0000, $past(s_q.reload[acc_idx])});
    endproperty
    a_read_reload: assert property (p_read_reload) else $error("bad reload readback");

    property p_read_unmapped;
        (rd_setup && !acc_ok) |=> (prdata == 32'h0000_0000);
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped data");

    property p_read_stands;
        !rd_setup |=> $stable(prdata);
    endproperty
    a_read_stands: assert property (p_read_stands) else $error("read data changed");

endmodule

`default_nettype wire

// ===== testbench/cdt_clock_unit.sv
// Clock unit model: one-cycle timer ticks for each timer module
`timescale 1ns/1ps
`default_nettype none
module cdt_clock_unit #(
    parameter int DIV = 3
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic run_a,
    input wire logic run_b,
    output logic tick_module_a,
    output logic tick_module_b
);
    logic [7:0] div_q;
    // Shared divider; ticks stay low while a module is not running
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            div_q <= 8'h00;
            tick_module_a <= 1'b0;
            tick_module_b <= 1'b0;
        end else begin
            div_q <= (div_q == 8'(DIV - 1)) ? 8'h00 : div_q + 8'h01;
            tick_module_a <= run_a && (div_q == 8'h00);
            tick_module_b <= run_b && (div_q == 8'h01);
        end
    end
endmodule
`default_nettype wire

// ===== testbench/cdt_timers_tb.sv
// Self-checking bench for the cascadable down timers
`timescale 1ns/1ps
`default_nettype none
module cdt_timers_tb
    import cdt_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    cdt_apb_req_t req = '0;
    logic [31:0] prdata;
    logic [3:0] timer_irq;
    logic timer_out;
    logic tick_module_a;
    logic tick_module_b;
    logic [1:0] run = 2'b00;
    logic [31:0] exp_q[$];
    logic [15:0] rv;
    int miscompares = 0;
    int compares = 0;
    // ------------------------------------------------------------
    // Clock, design and clock unit
    // ------------------------------------------------------------
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    cdt_timers i_dut (.clk_sys(clk_sys), .reset(reset), .apb_req(req), .prdata(prdata),
        .tick_module_a(tick_module_a), .tick_module_b(tick_module_b),
        .timer_irq(timer_irq), .timer_out(timer_out));
    cdt_clock_unit i_ck (.clk_sys(clk_sys), .reset(reset), .run_a(run[0]), .run_b(run[1]),
        .tick_module_a(tick_module_a), .tick_module_b(tick_module_b));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("Counts: compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Full-word bus cycle: setup phase, then access phase
    task automatic bus(input logic wr, input logic [12:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        #1 req = '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk_sys);
        #1 req.penable = 1'b1;
        @(posedge clk_sys);
        #1 req.psel = 1'b0;
        req.penable = 1'b0;
    endtask
    task automatic rd(input logic [12:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // Let n clock-unit ticks reach module m
    task automatic ticks(input int m, input int n);
        int i;
        i = 0;
        run[m] = 1'b1;
        while (i < n) begin
            @(posedge clk_sys);
            if ((m == 0) ? tick_module_a : tick_module_b) begin
                i++;
            end
        end
        #1 run[m] = 1'b0;
    endtask
    function automatic logic [12:0] ta(input int t, input logic [3:0] o);
        ta = 13'(CDT_MODULE_STRIDE * (t / 2) + CDT_TIMER_STRIDE * (t % 2) + o);
    endfunction
    // Oldest noted read result against the data of each read access phase
    always @(posedge clk_sys) begin
        if (req.psel && req.penable && !req.pwrite && exp_q.size() > 0) begin
            check(prdata, exp_q.pop_front());
        end
    end
    // Watchdog
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h4a3ef5ca));
        repeat (6) @(posedge clk_sys);
        #1 reset = 1'b0;
        // Reset values, random reloads, read-only count, unmapped space
        for (int t = 0; t < 4; t++) begin
            rd(ta(t, CDT_OFS_COUNT), {16'h0, CDT_COUNT_RESET});
            rd(ta(t, CDT_OFS_RELOAD), 32'h0);
            rd(ta(t, CDT_OFS_SETUP), 32'h0);
            rv = 16'($urandom);
            bus(1'b1, ta(t, CDT_OFS_RELOAD), {16'h0, rv});
            bus(1'b1, ta(t, CDT_OFS_COUNT), 32'h0000_1234);
            rd(ta(t, CDT_OFS_RELOAD), {16'h0, rv});
            rd(ta(t, CDT_OFS_COUNT), {16'h0, CDT_COUNT_RESET});
        end
        rd(13'h0040, 32'h0);
        $display("Test registers done");
        // Free-run timer 0 with its cascade bit set, periodic timer 1
        bus(1'b1, ta(0, CDT_OFS_RELOAD), 32'h2);
        bus(1'b1, ta(1, CDT_OFS_RELOAD), 32'h3);
        bus(1'b1, ta(0, CDT_OFS_SETUP), 32'h90);
        bus(1'b1, ta(1, CDT_OFS_SETUP), 32'hc0);
        rd(ta(0, CDT_OFS_COUNT), 32'h2);
        ticks(0, 3);
        rd(ta(0, CDT_OFS_COUNT), {16'h0, CDT_COUNT_RESET});
        rd(ta(1, CDT_OFS_COUNT), 32'h0);
        ticks(0, 1);
        rd(ta(1, CDT_OFS_COUNT), 32'h3);
        check({28'h0, timer_irq}, 32'h3);
        bus(1'b1, ta(0, CDT_OFS_ACK), $urandom);
        #20 check({28'h0, timer_irq}, 32'h2);
        bus(1'b1, ta(1, CDT_OFS_ACK), 32'h0);
        $display("Test free-run and periodic done");
        // Periodic timer 2 feeding cascaded periodic timer 3
        bus(1'b1, ta(2, CDT_OFS_RELOAD), 32'h1);
        bus(1'b1, ta(3, CDT_OFS_RELOAD), 32'h2);
        bus(1'b1, ta(3, CDT_OFS_SETUP), 32'hdc);
        bus(1'b1, ta(2, CDT_OFS_SETUP), 32'hc0);
        rd(ta(3, CDT_OFS_SETUP), 32'hdc);
        ticks(1, 1);
        rd(ta(3, CDT_OFS_COUNT), 32'h2);
        ticks(1, 1);
        rd(ta(3, CDT_OFS_COUNT), 32'h1);
        check({31'h0, timer_out}, 32'h0);
        ticks(1, 2);
        #20 check({31'h0, timer_out}, 32'h1);
        ticks(1, 2);
        rd(ta(3, CDT_OFS_COUNT), 32'h2);
        check({28'h0, timer_irq}, 32'h8);
        $display("Test cascade done");
        final_report();
    end
endmodule
`default_nettype wire
